// File: logic/sfp_pkg.sv
// constants shared by the protection and identification command block
// assumes a 100 MHz system clock that oversamples the serial link pins
package sfp_pkg;

  // ****************************************
  // opcodes
  // ****************************************
  localparam logic [7:0] OPC_STATUS_WRITE  = 8'h01;
  localparam logic [7:0] OPC_WRITE_LATCH   = 8'h06;
  localparam logic [7:0] OPC_STATUS_ARM    = 8'h50;
  localparam logic [7:0] OPC_JEDEC_ID      = 8'h9F;
  localparam logic [7:0] OPC_ADDR_ID_A     = 8'h90;
  localparam logic [7:0] OPC_ADDR_ID_B     = 8'hAB;

  // ****************************************
  // status byte field positions
  // ****************************************
  localparam int unsigned ST_BP_LO_POS  = 2;
  localparam int unsigned ST_BP_MID_POS = 3;
  localparam int unsigned ST_BP_HI_POS  = 4;
  localparam int unsigned ST_LOCK_POS   = 7;
  localparam logic [2:0]  BP_RESET      = 3'h0;
  localparam logic        LOCK_RESET    = 1'b0;

  // ****************************************
  // frame counts
  // ****************************************
  localparam logic [4:0] CMD_LAST_BIT   = 5'h07;
  localparam logic [4:0] ADDR_LAST_BIT  = 5'h17;
  localparam logic [2:0] TX_LAST_BIT    = 3'h7;
  localparam logic [1:0] JEDEC_LAST_IDX = 2'h2;
  localparam logic [1:0] JEDEC_DONE_IDX = 2'h3;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS     = 10;
  localparam int unsigned STATUS_CYCLE_NS   = 1000;
  localparam int unsigned STATUS_CYCLE_CLKS = (STATUS_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // frame decoder states
  // ****************************************
  typedef enum logic [2:0] {
    SFP_IDLE      = 3'b000,
    SFP_CMD       = 3'b001,
    SFP_ADDR      = 3'b010,
    SFP_JEDEC_OUT = 3'b011,
    SFP_ALT_OUT   = 3'b100,
    SFP_ST_DATA   = 3'b101,
    SFP_ST_HOLD   = 3'b110,
    SFP_IGNORE    = 3'b111
  } sfp_state_t;

endpackage

// File: logic/sfp_sync.sv
// two flip-flop synchroniser for a group of independent pin levels
// assumes each bit is a slow level or a link clock well below clk_in
`timescale 1ns/1ps
module sfp_sync #(
  parameter int unsigned WIDTH = 4,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             clk_in,
  input  wire logic             nrst_in,
  input  wire logic             ce_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;

  initial begin
    if (WIDTH < 1) $error("sfp_sync width must be at least one");
  end

  // stage1 is read only by the second stage
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stage1_reg <= INIT;
      sync_out   <= INIT;
    end else if (ce_in) begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end

endmodule

// File: logic/sfp_core.sv
// protection-field write and identification command block of a serial flash
// assumes sck/cs/si/wp arrive from pins and array_busy_in from on-chip logic
//
// Summary of operation
// - status write changes only the three protect-level bits and lock bit
// - new status value commits only on chip select rising after the frame
// - status write discarded when write-protect low and lock already set
// - with write-protect low, lock may go 0 to 1 but never 1 to 0
// - with write-protect high, lock and protect levels are freely writable
// - permission judged from lock and write-protect just before select rises
// - one permitted write may set lock and all three levels together
// - signature read shifts an 8-bit signature out on serial output
// - signature read ignored while erase, program or status cycle runs
// - opcode 9F returns maker byte, then memory type and capacity bytes
// - three-byte id output stops at once when chip select rises
// - address id read accepts opcode 90 or AB then a 24-bit address
// - address 0 returns maker byte, address 1 returns device byte
// - maker and device bytes alternate from the addressed one until select rises
// - status write must directly follow the arm command or arming is lost
// - serial bytes move most significant bit first
`timescale 1ns/1ps
module sfp_core #(
  parameter logic [7:0] MFR_ID   = 8'hA5, // arbitrary value
  parameter logic [7:0] MEM_TYPE = 8'h5A, // arbitrary value
  parameter logic [7:0] MEM_CAP  = 8'h3C, // arbitrary value
  parameter logic [7:0] DEV_ID   = 8'hC3, // arbitrary value
  parameter int unsigned STATUS_CLKS = sfp_pkg::STATUS_CYCLE_CLKS
) (
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic       ce_in,
  input  wire logic       sck_in,
  input  wire logic       cs_n_in,
  input  wire logic       si_in,
  input  wire logic       wp_n_in,
  input  wire logic       array_busy_in,
  output logic            so_out,
  output logic            so_oe_n_out,
  output logic [2:0]      block_protect_level_out,
  output logic            protect_lock_bit_out,
  output logic            status_cycle_busy_out
);
  import sfp_pkg::*;

  localparam int unsigned BW = (STATUS_CLKS > 1) ? $clog2(STATUS_CLKS + 1) : 1;

  initial begin
    if (STATUS_CLKS < 1) $error("sfp_core status cycle must last at least one clock");
  end

  // ****************************************
  // pin synchronisation and link edges
  // ****************************************
  logic [3:0] pins_sync;
  logic       sck_s;
  logic       cs_n_s;
  logic       si_s;
  logic       wp_n_s;
  logic       sck_prev_reg;
  logic       cs_prev_reg;

  sfp_sync #(.WIDTH(4), .INIT(4'h6)) u_sync (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .ce_in    (ce_in),
    .async_in ({sck_in, cs_n_in, si_in, wp_n_in}),
    .sync_out (pins_sync)
  );

  assign sck_s  = pins_sync[3];
  assign cs_n_s = pins_sync[2];
  assign si_s   = pins_sync[1];
  assign wp_n_s = pins_sync[0];

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sck_prev_reg <= 1'b0;
      cs_prev_reg  <= 1'b1;
    end else if (ce_in) begin
      sck_prev_reg <= sck_s;
      cs_prev_reg  <= cs_n_s;
    end
  end

  wire sel      = !cs_n_s;
  wire sck_rise = sel && sck_s && !sck_prev_reg;
  wire sck_fall = sel && !sck_s && sck_prev_reg;
  wire cs_rise  = cs_n_s && !cs_prev_reg;

  // ****************************************
  // frame state
  // ****************************************
  sfp_state_t state_reg;
  sfp_state_t state_next;
  logic [7:0] rx_reg;
  logic [4:0] bit_cnt_reg;
  logic [7:0] tx_reg;
  logic [2:0] tx_cnt_reg;
  logic [1:0] id_idx_reg;
  logic       alt_sel_reg;
  logic       arm_reg;
  logic       arm_frame_reg;
  logic [2:0] bp_reg;
  logic       lock_reg;
  logic [2:0] new_bp_reg;
  logic       new_lock_reg;
  logic [BW-1:0] st_cnt_reg;
  logic       so_reg;
  logic       so_oe_n_reg;
  logic       busy_reg;

  // byte selection for both identification forms
  function automatic logic [7:0] id_byte(input logic jedec, input logic [1:0] idx,
                                         input logic [7:0] mfr, input logic [7:0] typ,
                                         input logic [7:0] cap, input logic [7:0] dev);
    logic [7:0] b;
    b = 8'h00;
    if (jedec) begin
      case (idx)
        2'h0:    b = mfr;
        2'h1:    b = typ;
        2'h2:    b = cap;
        default: b = 8'h00;
      endcase
    end else begin
      b = idx[0] ? dev : mfr;
    end
    return b;
  endfunction

  wire [7:0] rx_full   = {rx_reg[6:0], si_s};
  wire       cmd_done  = sck_rise && (bit_cnt_reg == CMD_LAST_BIT);
  wire       addr_done = sck_rise && (bit_cnt_reg == ADDR_LAST_BIT);
  wire       st_cycle  = (st_cnt_reg != '0);
  wire       busy_now  = array_busy_in || st_cycle;
  wire       is_addr_id = (rx_full == OPC_ADDR_ID_A) || (rx_full == OPC_ADDR_ID_B);
  wire       is_arm     = (rx_full == OPC_STATUS_ARM) || (rx_full == OPC_WRITE_LATCH);
  wire       out_phase  = (state_reg == SFP_JEDEC_OUT) || (state_reg == SFP_ALT_OUT);
  // lock blocks the write only while write-protect is low, judged before cs rises
  wire       st_permit  = wp_n_s || !lock_reg;
  wire       st_commit  = cs_rise && (state_reg == SFP_ST_HOLD) && st_permit;
  wire [7:0] first_alt  = id_byte(1'b0, {1'b0, rx_full[0]}, MFR_ID, MEM_TYPE, MEM_CAP, DEV_ID);
  wire [7:0] next_tx    = id_byte(state_reg == SFP_JEDEC_OUT,
                                  (state_reg == SFP_JEDEC_OUT) ? id_idx_reg + 2'h1
                                                               : {1'b0, !alt_sel_reg},
                                  MFR_ID, MEM_TYPE, MEM_CAP, DEV_ID);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SFP_IDLE:      state_next = sel ? SFP_CMD : SFP_IDLE;
      SFP_CMD: begin
        if (cmd_done) begin
          if (rx_full == OPC_JEDEC_ID)                   state_next = SFP_JEDEC_OUT;
          else if (is_addr_id && !busy_now)              state_next = SFP_ADDR;
          else if (rx_full == OPC_STATUS_WRITE && arm_reg) state_next = SFP_ST_DATA;
          else                                           state_next = SFP_IGNORE;
        end
      end
      SFP_ADDR:      state_next = addr_done ? SFP_ALT_OUT : SFP_ADDR;
      SFP_ST_DATA:   state_next = cmd_done ? SFP_ST_HOLD : SFP_ST_DATA;
      SFP_JEDEC_OUT: state_next = SFP_JEDEC_OUT;
      SFP_ALT_OUT:   state_next = SFP_ALT_OUT;
      SFP_ST_HOLD:   state_next = SFP_ST_HOLD;
      SFP_IGNORE:    state_next = SFP_IGNORE;
      default:       state_next = SFP_IDLE;
    endcase
    if (!sel) state_next = SFP_IDLE;
  end

  // ****************************************
  // receive side
  // ****************************************
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg   <= SFP_IDLE;
      rx_reg      <= 8'h00;
      bit_cnt_reg <= 5'h00;
    end else if (ce_in) begin
      state_reg <= state_next;
      if (!sel || state_next != state_reg) begin
        bit_cnt_reg <= 5'h00;
      end else if (sck_rise) begin
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
      if (sck_rise) rx_reg <= rx_full;
    end
  end

  // ****************************************
  // status fields and write arming
  // ****************************************
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      arm_reg       <= 1'b0;
      arm_frame_reg <= 1'b0;
      new_bp_reg    <= BP_RESET;
      new_lock_reg  <= LOCK_RESET;
      bp_reg        <= BP_RESET;
      lock_reg      <= LOCK_RESET;
      st_cnt_reg    <= '0;
    end else if (ce_in) begin
      if (state_reg == SFP_CMD && cmd_done) arm_frame_reg <= is_arm;
      else if (state_reg != SFP_CMD && sck_rise) arm_frame_reg <= 1'b0;
      // arming lasts exactly one following frame
      if (cs_rise) arm_reg <= arm_frame_reg && state_reg == SFP_IGNORE;
      if (cs_rise) arm_frame_reg <= 1'b0;
      if (state_reg == SFP_ST_DATA && cmd_done) begin
        new_bp_reg   <= {rx_full[ST_BP_HI_POS], rx_full[ST_BP_MID_POS], rx_full[ST_BP_LO_POS]};
        new_lock_reg <= rx_full[ST_LOCK_POS];
      end
      // only the protect levels and the lock are touched
      if (st_commit) begin
        bp_reg     <= new_bp_reg;
        lock_reg   <= new_lock_reg || (lock_reg && !wp_n_s);
        st_cnt_reg <= BW'(STATUS_CLKS);
      end else if (st_cycle) begin
        st_cnt_reg <= st_cnt_reg - BW'(1);
      end
    end
  end

  // ****************************************
  // transmit side
  // ****************************************
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tx_reg      <= 8'h00;
      tx_cnt_reg  <= 3'h0;
      id_idx_reg  <= 2'h0;
      alt_sel_reg <= 1'b0;
    end else if (ce_in) begin
      if (state_reg == SFP_CMD && state_next == SFP_JEDEC_OUT) begin
        tx_reg     <= MFR_ID;
        tx_cnt_reg <= 3'h0;
        id_idx_reg <= 2'h0;
      end else if (state_reg == SFP_ADDR && state_next == SFP_ALT_OUT) begin
        tx_reg      <= first_alt;
        tx_cnt_reg  <= 3'h0;
        alt_sel_reg <= rx_full[0];
      end else if (out_phase && sck_fall) begin
        tx_cnt_reg <= tx_cnt_reg + 3'h1;
        if (tx_cnt_reg == TX_LAST_BIT) begin
          // past the third id byte the output simply reads zero
          if (state_reg == SFP_JEDEC_OUT) begin
            tx_reg     <= (id_idx_reg >= JEDEC_LAST_IDX) ? 8'h00 : next_tx;
            id_idx_reg <= (id_idx_reg == JEDEC_DONE_IDX) ? id_idx_reg : id_idx_reg + 2'h1;
          end else begin
            tx_reg      <= next_tx;
            alt_sel_reg <= !alt_sel_reg;
          end
        end else begin
          tx_reg <= {tx_reg[6:0], 1'b0};
        end
      end
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      so_reg      <= 1'b0;
      so_oe_n_reg <= 1'b1;
      busy_reg    <= 1'b0;
    end else if (ce_in) begin
      if (out_phase && sck_fall) so_reg <= tx_reg[7];
      so_oe_n_reg <= !(out_phase && sel);
      busy_reg    <= busy_now;
    end
  end

  assign so_out                  = so_reg;
  assign so_oe_n_out             = so_oe_n_reg;
  assign block_protect_level_out = bp_reg;
  assign protect_lock_bit_out    = lock_reg;
  assign status_cycle_busy_out   = busy_reg;

endmodule

// File: tb/sfp_core_props.sv
// port assertions for the protection and identification block
// assumes a bind onto sfp_core, one clock domain, async low reset
`timescale 1ns/1ps
module sfp_core_props #(
  parameter int unsigned STATUS_CLKS = 4
) (
  input wire logic       clk_in,
  input wire logic       nrst_in,
  input wire logic       sck_in,
  input wire logic       cs_n_in,
  input wire logic       wp_n_in,
  input wire logic       array_busy_in,
  input wire logic       so_out,
  input wire logic       so_oe_n_out,
  input wire logic [2:0] block_protect_level_out,
  input wire logic       protect_lock_bit_out,
  input wire logic       status_cycle_busy_out
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_commit;
    $changed({block_protect_level_out, protect_lock_bit_out});
  endsequence
  // four busy clocks hold for any STATUS_CLKS of 4 or more
  sequence s_cycle;
    status_cycle_busy_out [*4];
  endsequence
  // the commit logic sees the write-protect pin two clocks late
  property p_frozen;
    protect_lock_bit_out && !$past(wp_n_in, 2)
      |=> $stable(block_protect_level_out) && protect_lock_bit_out;
  endproperty
  a_commit_at_cs: assert property (s_commit |-> cs_n_in && $past(cs_n_in, 2))
    else $error("protect fields changed inside a frame");
  a_commit_busy: assert property (s_commit |=> s_cycle)
    else $error("no status cycle after commit");
  a_busy_follow: assert property (array_busy_in |=> status_cycle_busy_out)
    else $error("busy output missed array busy");
  a_lock_no_clear: assert property ($fell(protect_lock_bit_out) |-> $past(wp_n_in, 3))
    else $error("lock cleared with write protect low");
  a_locked_frozen: assert property (p_frozen)
    else $error("locked fields changed");
  a_oe_release: assert property (cs_n_in [*6] |-> so_oe_n_out)
    else $error("output still enabled after select rose");
  a_oe_in_frame: assert property (!so_oe_n_out |-> !$past(cs_n_in, 6))
    else $error("output enabled outside a frame");
  a_so_on_low: assert property ($changed(so_out) && !so_oe_n_out |-> !sck_in && !$past(sck_in, 2))
    else $error("output bit moved while clock high");
endmodule

bind sfp_core sfp_core_props #(.STATUS_CLKS(STATUS_CLKS)) sfp_core_props_i (
  .clk_in, .nrst_in, .sck_in, .cs_n_in, .wp_n_in, .array_busy_in, .so_out, .so_oe_n_out,
  .block_protect_level_out, .protect_lock_bit_out, .status_cycle_busy_out
);

// File: tb/sfp_host.sv
// host serial master model: clock, select and data in, mode 0
// assumes its clock is parked low between frames and never runs free
`timescale 1ns/1ps
module sfp_host (
  input  wire logic clk_in,
  input  wire logic so_in,
  output logic      sck_out  = 1'b0,
  output logic      cs_n_out = 1'b1,
  output logic      si_out   = 1'b1
);
  // ****************************************
  // frame tasks
  // ****************************************
  localparam realtime HALF = 62.5;
  // one ns past a falling edge keeps every pin edge off the rising edges
  task automatic open_frame();
    @(negedge clk_in);
    #1;
    cs_n_out = 1'b0;
    #(HALF);
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si_out = tx[i];
      #(HALF);
      sck_out = 1'b1;
      rx[i] = so_in;
      #(HALF);
      sck_out = 1'b0;
    end
  endtask
  task automatic close_frame();
    #(HALF);
    cs_n_out = 1'b1;
    si_out = ~si_out;
    #200;
  endtask
endmodule

// File: tb/sfp_core_bench.sv
// self-checking bench for the protection and identification block
// assumes sfp_host drives the link and the checker is bound to sfp_core
`timescale 1ns/1ps
module sfp_core_bench;
  import sfp_pkg::*;
  localparam logic [7:0] MFR = 8'hA5; // arbitrary value
  localparam logic [7:0] TYP = 8'h5A; // arbitrary value
  localparam logic [7:0] CAP = 8'h3C; // arbitrary value
  localparam logic [7:0] DEV = 8'hC3; // arbitrary value
  localparam logic [7:0] OPS [2] = '{OPC_ADDR_ID_A, OPC_ADDR_ID_B};
  logic       clk_in = 1'b0;
  logic       nrst_in = 1'b0;
  logic       wp_n_in = 1'b1;
  logic       busy_in = 1'b0;
  logic       ce_in = 1'b1;
  logic       oe_seen = 1'b0;
  logic [7:0] rx [$];
  int         n_errors = 0;
  int         n_tests = 0;
  wire logic       sck, cs_n, si, so, so_oe_n, lock, busy_out;
  wire logic [2:0] bp;
  wire logic [7:0] st = {4'h0, bp, lock};
  // ****************************************
  // design, host and tasks
  // ****************************************
  sfp_core #(.MFR_ID(MFR), .MEM_TYPE(TYP), .MEM_CAP(CAP), .DEV_ID(DEV), .STATUS_CLKS(4))
  sfp_core_i (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce_in), .sck_in(sck), .cs_n_in(cs_n),
    .si_in(si), .wp_n_in(wp_n_in), .array_busy_in(busy_in), .so_out(so), .so_oe_n_out(so_oe_n),
    .block_protect_level_out(bp), .protect_lock_bit_out(lock), .status_cycle_busy_out(busy_out));
  // a released output reads back inverted so a stale bit never matches
  sfp_host sfp_host_i (.clk_in(clk_in), .so_in(so_oe_n ? ~so : so), .sck_out(sck),
    .cs_n_out(cs_n), .si_out(si));
  always #5 clk_in = ~clk_in;
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_tests++;
    if (seen !== want) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic frame(input logic [7:0] tx [$]);
    logic [7:0] r;
    rx = {};
    sfp_host_i.open_frame();
    foreach (tx[i]) begin
      sfp_host_i.xfer(tx[i], r);
      rx.push_back(r);
    end
    // output enable is taken while select is still low
    oe_seen = !so_oe_n;
    sfp_host_i.close_frame();
  endtask
  task automatic wr(input logic [7:0] arm, input logic [7:0] d);
    frame({arm});
    frame({OPC_STATUS_WRITE, d});
  endtask
  function automatic logic [7:0] fld(input logic [7:0] d);
    return {4'h0, d[ST_BP_HI_POS], d[ST_BP_MID_POS], d[ST_BP_LO_POS], d[ST_LOCK_POS]};
  endfunction
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #500_000;
    n_errors++;
    conclude();
  end
  initial begin
    repeat (4) @(negedge clk_in);
    nrst_in = 1'b1;
    repeat (4) @(negedge clk_in);
    check(st, 8'h00);
    check(so_oe_n, 8'h01);
    frame({OPC_STATUS_WRITE, 8'hFF});
    check(st, 8'h00);
    wr(OPC_STATUS_ARM, 8'hE7);
    check(st, fld(8'hE7));
    @(negedge clk_in) wp_n_in = 1'b0;
    wr(OPC_STATUS_ARM, 8'h1C);
    check(st, fld(8'hE7));
    @(negedge clk_in) wp_n_in = 1'b1;
    wr(OPC_WRITE_LATCH, 8'h00);
    check(st, 8'h00);
    @(negedge clk_in) wp_n_in = 1'b0;
    wr(OPC_STATUS_ARM, 8'h9C);
    check(st, fld(8'h9C));
    wr(OPC_STATUS_ARM, 8'h00);
    check(st, fld(8'h9C));
    @(negedge clk_in) wp_n_in = 1'b1;
    frame({OPC_STATUS_ARM});
    frame({OPC_JEDEC_ID, 8'h00});
    frame({OPC_STATUS_WRITE, 8'h00});
    check(st, fld(8'h9C));
    frame({OPC_JEDEC_ID, 8'h00, 8'h00, 8'h00, 8'h00});
    check(rx[1], MFR);
    check(rx[2], TYP);
    check(rx[3], CAP);
    frame({OPC_JEDEC_ID, 8'h00});
    check(oe_seen, 8'h01);
    check(so_oe_n, 8'h01);
    foreach (OPS[k]) begin
      for (int a = 0; a < 2; a++) begin
        frame({OPS[k], 8'h00, 8'h00, 8'(a), 8'h00, 8'h00, 8'h00});
        check(oe_seen, 8'h01);
        check(rx[4], a ? DEV : MFR);
        check(rx[5], a ? MFR : DEV);
        check(rx[6], a ? DEV : MFR);
      end
    end
    @(negedge clk_in) busy_in = 1'b1;
    frame({OPC_ADDR_ID_B, 8'h00, 8'h00, 8'h00, 8'h00});
    check(oe_seen, 8'h00);
    check(busy_out, 8'h01);
    @(negedge clk_in) busy_in = 1'b0;
    // a frozen block must let a whole permitted write pass unseen
    @(negedge clk_in) ce_in = 1'b0;
    wr(OPC_STATUS_ARM, 8'h00);
    @(negedge clk_in) ce_in = 1'b1;
    repeat (4) @(negedge clk_in);
    check(st, fld(8'h9C));
    check(so_oe_n, 8'h01);
    conclude();
  end
endmodule
